//--- logic/pd_input_cfg_pkg.sv
/*
  constants, field layout and carrier types for the photodiode input
  configuration register bank.
  assumes a 32-bit apb register bus with byte addresses in paddr.
*/
package pd_input_cfg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PDCFG_OFFSET    = 8'h08;
  localparam logic [7:0] FEMODE_OFFSET   = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h34;

  // ----------------------------------------------------------------
  // photodiode_input_config field positions
  // ----------------------------------------------------------------
  localparam int HOLD_BIT  = 25;
  localparam int FLAG_LSB  = 20;
  localparam int FLAG_W    = 4;
  localparam int OFFS_LSB  = 8;
  localparam int OFFS_W    = 8;
  localparam int PD_LSB    = 2;
  localparam int PD_W      = 4;
  localparam int AUX_LSB   = 0;
  localparam int AUX_W     = 2;

  // ----------------------------------------------------------------
  // front-end mode register field positions
  // ----------------------------------------------------------------
  localparam int MAN_BIT   = 0;
  localparam int SWITG_BIT = 1;
  localparam int DCTRL_LSB = 2;

  // ----------------------------------------------------------------
  // reset values and scale
  // ----------------------------------------------------------------
  localparam logic [31:0] PDCFG_RESET  = 32'h0000_0000;
  localparam logic [5:0]  FEMODE_RESET = 6'h00;
  localparam logic [3:0]  IRQ_RESET    = 4'h0;
  localparam int          OFFSET_STEP_NA = 10;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       hold;
    logic [7:0] offsetCode;
    logic [3:0] pdSel;
    logic [1:0] auxSel;
  } pd_cfg_t;

  typedef struct packed {
    logic       manualMode;
    logic       swIntegrate;
    logic [3:0] diodeCtrlEn;
  } fe_mode_t;

  typedef struct packed {
    logic       weightPlus;
    logic       weightMinus;
    logic       seqIntegrate;
    logic [3:0] seqDiodeOn;
  } seq_in_t;

  typedef struct packed {
    logic [3:0] pdConnect;
    logic       auxSevenConnect;
    logic       auxSixConnect;
    logic [7:0] offsetCode;
    logic       offsetEnable;
    logic       integrate;
    logic       demodForceRef;
    logic       demodTristate;
  } afe_ctrl_t;

endpackage : pd_input_cfg_pkg

//--- logic/led_sink_flag.sv
/*
  one led current-sink supply flag: software sets it, a low sink
  voltage clears it and reports the clearing as a one-cycle event.
  assumes sinkLow is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module led_sink_flag
  import pd_input_cfg_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic writeSet,
  input  wire logic sinkLow,
  output logic      flag,
  output logic      clearEvent
);

  logic flag_reg;

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  // a low sink wins over a simultaneous write so no dip is missed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 1'b0;
    end else if (sinkLow) begin
      flag_reg <= 1'b0;
    end else if (writeSet) begin
      flag_reg <= 1'b1;
    end
  end

  assign flag       = flag_reg;
  assign clearEvent = flag_reg & sinkLow;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_flag_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    sinkLow |=> !flag_reg)
    else $error("sink flag not cleared by low supply");

  a_flag_set: assert property (
    @(posedge clk) disable iff (!arst_n)
    writeSet && !sinkLow |=> flag_reg)
    else $error("sink flag not set by write");

endmodule : led_sink_flag

`default_nettype wire

//--- logic/photodiode_input_config_reg.sv
/*
  photodiode input configuration register bank with apb slave,
  front-end mode register and sink-event interrupt.
  assumes apb signals, sequencer inputs and sink levels are all
  synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module photodiode_input_config_reg
  import pd_input_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire seq_in_t     seqIn,
  input  wire logic [3:0]  sinkLow,
  output afe_ctrl_t        afeCtrl,
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pd_cfg_t    cfg_reg;
  fe_mode_t   mode_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [31:0] prdata_reg;
  afe_ctrl_t  ctrl_reg;
  afe_ctrl_t  ctrl_next;
  logic [3:0] flagSet;
  logic [3:0] sinkFlag;
  logic [3:0] sinkEvent;
  logic [31:0] readMux;
  logic       access;
  logic       wrEn;
  logic       hitCfg;
  logic       hitMode;
  logic       hitStat;
  logic       hitMask;
  logic       mapped;
  logic [31:0] cfgWord;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign access = psel & penable;
  assign pready = 1'b1;

  always_comb begin
    hitCfg  = 1'b0;
    hitMode = 1'b0;
    hitStat = 1'b0;
    hitMask = 1'b0;
    if (paddr == PDCFG_OFFSET) begin
      hitCfg = 1'b1;
    end else if (paddr == FEMODE_OFFSET) begin
      hitMode = 1'b1;
    end else if (paddr == IRQ_STAT_OFFSET) begin
      hitStat = 1'b1;
    end else if (paddr == IRQ_MASK_OFFSET) begin
      hitMask = 1'b1;
    end
  end

  assign mapped  = hitCfg | hitMode | hitStat | hitMask;
  assign wrEn    = access & pwrite & mapped;
  assign pslverr = access & ~mapped;

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  // only documented fields are stored; other write bits are dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg.hold       <= PDCFG_RESET[HOLD_BIT];
      cfg_reg.offsetCode <= PDCFG_RESET[OFFS_LSB +: OFFS_W];
      cfg_reg.pdSel      <= PDCFG_RESET[PD_LSB +: PD_W];
      cfg_reg.auxSel     <= PDCFG_RESET[AUX_LSB +: AUX_W];
    end else if (wrEn && hitCfg) begin
      cfg_reg.hold       <= pwdata[HOLD_BIT];
      cfg_reg.offsetCode <= pwdata[OFFS_LSB +: OFFS_W];
      cfg_reg.pdSel      <= pwdata[PD_LSB +: PD_W];
      cfg_reg.auxSel     <= pwdata[AUX_LSB +: AUX_W];
    end
  end

  // ----------------------------------------------------------------
  // led sink supply flags
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
      assign flagSet[i] = wrEn & hitCfg & pwdata[FLAG_LSB + i];

      led_sink_flag u_flag (
        .clk        (clk),
        .arst_n     (arst_n),
        .writeSet   (flagSet[i]),
        .sinkLow    (sinkLow[i]),
        .flag       (sinkFlag[i]),
        .clearEvent (sinkEvent[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // front-end mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= fe_mode_t'(FEMODE_RESET);
    end else if (wrEn && hitMode) begin
      mode_reg.manualMode  <= pwdata[MAN_BIT];
      mode_reg.swIntegrate <= pwdata[SWITG_BIT];
      mode_reg.diodeCtrlEn <= pwdata[DCTRL_LSB +: PD_W];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // a new event in the clearing cycle stays set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= IRQ_RESET;
    end else begin
      status_reg <= (status_reg & ~((wrEn && hitStat) ? pwdata[3:0] : 4'h0))
                    | sinkEvent;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= IRQ_RESET;
    end else if (wrEn && hitMask) begin
      mask_reg <= pwdata[3:0];
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    cfgWord = 32'h0000_0000;
    cfgWord[HOLD_BIT] = cfg_reg.hold;
    cfgWord[FLAG_LSB +: FLAG_W] = sinkFlag;
    cfgWord[OFFS_LSB +: OFFS_W] = cfg_reg.offsetCode;
    cfgWord[PD_LSB +: PD_W] = cfg_reg.pdSel;
    cfgWord[AUX_LSB +: AUX_W] = cfg_reg.auxSel;
  end

  always_comb begin
    readMux = 32'h0000_0000;
    if (hitCfg) begin
      readMux = cfgWord;
    end else if (hitMode) begin
      readMux[DCTRL_LSB +: PD_W] = mode_reg.diodeCtrlEn;
      readMux[SWITG_BIT] = mode_reg.swIntegrate;
      readMux[MAN_BIT] = mode_reg.manualMode;
    end else if (hitStat) begin
      readMux[3:0] = status_reg;
    end else if (hitMask) begin
      readMux[3:0] = mask_reg;
    end
  end

  // data is captured in the setup phase and stands through access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= readMux;
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // analog front-end controls
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = '0;
    ctrl_next.offsetCode   = cfg_reg.offsetCode;
    ctrl_next.offsetEnable = |cfg_reg.offsetCode;
    ctrl_next.auxSevenConnect = cfg_reg.auxSel[1];
    ctrl_next.auxSixConnect   = cfg_reg.auxSel[0];
    // sequencer diode gating applies only outside manual mode
    if (mode_reg.manualMode) begin
      ctrl_next.pdConnect = cfg_reg.pdSel;
    end else begin
      ctrl_next.pdConnect = cfg_reg.pdSel
        & (~mode_reg.diodeCtrlEn | seqIn.seqDiodeOn);
    end
    if (mode_reg.manualMode) begin
      ctrl_next.integrate = mode_reg.swIntegrate;
    end else begin
      ctrl_next.integrate = seqIn.seqIntegrate;
    end
    if (!seqIn.weightPlus && !seqIn.weightMinus) begin
      ctrl_next.demodForceRef = ~cfg_reg.hold;
      ctrl_next.demodTristate = cfg_reg.hold;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign afeCtrl = ctrl_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cfg_readback: assert property (
    @(posedge clk) disable iff (!arst_n)
    psel && !penable && !pwrite && paddr == PDCFG_OFFSET
    |=> prdata == $past(cfgWord))
    else $error("config readback wrong");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    access && !pwrite && paddr == PDCFG_OFFSET
    |-> prdata[31:26] == 6'h00 && prdata[19:16] == 4'h0
        && prdata[7:6] == 2'h0 && prdata[24] == 1'b0)
    else $error("reserved bits not zero");

  a_hold_ref: assert property (
    @(posedge clk) disable iff (!arst_n)
    !seqIn.weightPlus && !seqIn.weightMinus && !cfg_reg.hold
    |=> afeCtrl.demodForceRef && !afeCtrl.demodTristate)
    else $error("idle demod not forced to reference");

  a_hold_tri: assert property (
    @(posedge clk) disable iff (!arst_n)
    !seqIn.weightPlus && !seqIn.weightMinus && cfg_reg.hold
    |=> afeCtrl.demodTristate && !afeCtrl.demodForceRef)
    else $error("idle demod not tristated");

  a_offset_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    wrEn && hitCfg ##1 !(wrEn && hitCfg)
    |=> afeCtrl.offsetCode == $past(pwdata[15:8], 2)
        && afeCtrl.offsetEnable == ($past(pwdata[15:8], 2) != 8'h00))
    else $error("offset code not driven");

  a_pd_manual: assert property (
    @(posedge clk) disable iff (!arst_n)
    mode_reg.manualMode |=> afeCtrl.pdConnect == $past(cfg_reg.pdSel))
    else $error("photodiode select not applied");

  a_pd_gated: assert property (
    @(posedge clk) disable iff (!arst_n)
    !mode_reg.manualMode && (mode_reg.diodeCtrlEn & ~seqIn.seqDiodeOn) != 4'h0
    |=> (afeCtrl.pdConnect & $past(mode_reg.diodeCtrlEn & ~seqIn.seqDiodeOn))
        == 4'h0)
    else $error("sequencer diode gating ignored");

  a_aux_pins: assert property (
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> afeCtrl.auxSevenConnect == $past(cfg_reg.auxSel[1])
        && afeCtrl.auxSixConnect == $past(cfg_reg.auxSel[0]))
    else $error("aux pin connect wrong");

  a_integrate_src: assert property (
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> afeCtrl.integrate == ($past(mode_reg.manualMode)
        ? $past(mode_reg.swIntegrate) : $past(seqIn.seqIntegrate)))
    else $error("integration source wrong");

  a_irq_event: assert property (
    @(posedge clk) disable iff (!arst_n)
    |(sinkEvent & mask_reg) |=> irq)
    else $error("sink event did not raise interrupt");

  a_status_w1c: assert property (
    @(posedge clk) disable iff (!arst_n)
    wrEn && hitStat && sinkEvent == 4'h0
    |=> (status_reg & $past(pwdata[3:0])) == 4'h0)
    else $error("status bit not cleared by write of one");

  a_status_set_wins: assert property (
    @(posedge clk) disable iff (!arst_n)
    |sinkEvent |=> (status_reg & $past(sinkEvent)) == $past(sinkEvent))
    else $error("sink event lost in status");

  a_mask_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    wrEn && hitMask |=> mask_reg == $past(pwdata[3:0]))
    else $error("mask write not stored");

  a_unmapped_nowrite: assert property (
    @(posedge clk) disable iff (!arst_n)
    access && pwrite && !mapped |=> $stable({cfg_reg, mode_reg, mask_reg}))
    else $error("unmapped write changed a register");

  a_reset_zero: assert property (
    @(posedge clk)
    $rose(arst_n) |-> cfgWord == PDCFG_RESET && mode_reg == fe_mode_t'(FEMODE_RESET))
    else $error("register not at reset value after reset");

  a_offset_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_reg.offsetCode == 8'h00 |=> !afeCtrl.offsetEnable)
    else $error("offset source on with zero code");

  a_cfg_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    wrEn && hitCfg |=> cfg_reg.pdSel == $past(pwdata[PD_LSB +: PD_W])
        && cfg_reg.auxSel == $past(pwdata[AUX_LSB +: AUX_W]))
    else $error("connect fields not stored");

  a_demod_active: assert property (
    @(posedge clk) disable iff (!arst_n)
    seqIn.weightPlus || seqIn.weightMinus |=> !afeCtrl.demodForceRef && !afeCtrl.demodTristate)
    else $error("demod idle handling while weight active");

endmodule : photodiode_input_config_reg

`default_nettype wire

//--- dv/tb.sv
/*
  self-checking bench for the photodiode input configuration register bank.
  assumes the design package is compiled first and an apb slave that
  answers with pready.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import pd_input_cfg_pkg::*;
;
  // ------------------------------------------------------------
  // signals and dut
  // ------------------------------------------------------------
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  seq_in_t     seqIn;
  logic [3:0]  sinkLow;
  afe_ctrl_t   afeCtrl;
  logic        irq;
  int          n_fail;
  int          cmp_count;

  photodiode_input_config_reg u_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seqIn(seqIn), .sinkLow(sinkLow), .afeCtrl(afeCtrl), .irq(irq)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
  endtask : rdchk

  // control outputs lag the register by one cycle
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] addrs [4];
    addrs = '{PDCFG_OFFSET, FEMODE_OFFSET, IRQ_STAT_OFFSET, IRQ_MASK_OFFSET};
    foreach (addrs[i]) rdchk(addrs[i], 32'h0000_0000);
    chk(32'(afeCtrl), 32'h0000_0002, "controls after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields;
    wr(PDCFG_OFFSET, 32'hFFFF_FFFF);
    rdchk(PDCFG_OFFSET, 32'h02F0_FF3F);
    settle();
    chk(32'(afeCtrl.pdConnect), 32'hF, "all diodes");
    chk(32'({afeCtrl.auxSevenConnect, afeCtrl.auxSixConnect}), 32'h3, "aux");
    chk(32'({afeCtrl.offsetEnable, afeCtrl.offsetCode}), 32'h1FF, "offset max");
    for (int i = 0; i < 6; i++) begin
      wr(PDCFG_OFFSET, 32'h1 << i);
      settle();
      chk(32'({afeCtrl.pdConnect, afeCtrl.auxSevenConnect, afeCtrl.auxSixConnect}),
          32'h1 << i, "single connect");
      chk(32'(afeCtrl.offsetEnable), 32'h0, "offset off");
    end
    wr(PDCFG_OFFSET, 32'h0000_0100);
    settle();
    chk(32'({afeCtrl.offsetEnable, afeCtrl.offsetCode}), 32'h101, "offset one");
    $display("test fields done");
  endtask : t_fields

  task automatic t_demod;
    logic [1:0] exp [4];
    exp = '{2'b10, 2'b01, 2'b00, 2'b00};
    for (int i = 0; i < 4; i++) begin
      wr(PDCFG_OFFSET, (i == 1) ? (32'h1 << HOLD_BIT) : 32'h0);
      seqIn.weightPlus  <= (i == 2);
      seqIn.weightMinus <= (i == 3);
      settle();
      chk(32'({afeCtrl.demodForceRef, afeCtrl.demodTristate}), 32'(exp[i]), "demod");
    end
    @(posedge clk);
    seqIn.weightPlus  <= 1'b0;
    seqIn.weightMinus <= 1'b0;
    $display("test demod done");
  endtask : t_demod

  task automatic t_integrate;
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      wr(FEMODE_OFFSET, {30'h0, s[1], s[2]});
      seqIn.seqIntegrate <= s[0];
      settle();
      chk(32'(afeCtrl.integrate), 32'(s[2] ? s[1] : s[0]), "integrate");
    end
    $display("test integrate done");
  endtask : t_integrate

  task automatic t_diode;
    wr(PDCFG_OFFSET, 32'h0000_003C);
    wr(FEMODE_OFFSET, 32'h0000_003C);
    seqIn.seqDiodeOn <= 4'b0101;
    settle();
    chk(32'(afeCtrl.pdConnect), 32'h5, "gated diodes");
    wr(FEMODE_OFFSET, 32'h0000_003D);
    settle();
    chk(32'(afeCtrl.pdConnect), 32'hF, "manual ignores gate");
    wr(FEMODE_OFFSET, 32'h0000_000C);
    seqIn.seqDiodeOn <= 4'b1010;
    settle();
    chk(32'(afeCtrl.pdConnect), 32'hE, "partial gate");
    wr(FEMODE_OFFSET, 32'h0);
    $display("test diode done");
  endtask : t_diode

  task automatic pulse_low(input logic [3:0] m);
    @(posedge clk);
    sinkLow <= m;
    @(posedge clk);
    sinkLow <= 4'h0;
    settle();
  endtask : pulse_low

  task automatic t_flags;
    wr(PDCFG_OFFSET, 32'h00F0_0000);
    rdchk(PDCFG_OFFSET, 32'h00F0_0000);
    wr(IRQ_MASK_OFFSET, 32'h1);
    pulse_low(4'b0001);
    chk(32'(irq), 32'h1, "irq raised");
    rdchk(PDCFG_OFFSET, 32'h00E0_0000);
    rdchk(IRQ_STAT_OFFSET, 32'h1);
    wr(IRQ_STAT_OFFSET, 32'h1);
    rdchk(IRQ_STAT_OFFSET, 32'h0);
    chk(32'(irq), 32'h0, "irq cleared");
    pulse_low(4'b0010);
    rdchk(PDCFG_OFFSET, 32'h00C0_0000);
    chk(32'(irq), 32'h0, "irq masked");
    wr(IRQ_MASK_OFFSET, 32'h2);
    #1;
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(IRQ_STAT_OFFSET, 32'h2);
    #1;
    chk(32'(irq), 32'h0, "irq w1c");
    wr(PDCFG_OFFSET, 32'h00F0_0000);
    rdchk(PDCFG_OFFSET, 32'h00F0_0000);
    $display("test flags done");
  endtask : t_flags

  task automatic t_unmapped;
    logic [31:0] q;
    logic        e;
    wr(8'h44, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h44, 32'h0, q, e);
    chk(q, 32'h0, "unmapped data");
    chk(32'(e), 32'h1, "unmapped error");
    chk(32'(pready), 32'h1, "pready");
    xfer(1'b0, PDCFG_OFFSET, 32'h0, q, e);
    chk(32'(e), 32'h0, "mapped no error");
    chk(q, 32'h00F0_0000, "unchanged");
    $display("test unmapped done");
  endtask : t_unmapped

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    n_fail    = 0;
    cmp_count = 0;
    arst_n    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    seqIn     = '0;
    sinkLow   = 4'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_demod();
    t_integrate();
    t_diode();
    t_flags();
    t_unmapped();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

endmodule : tb

`default_nettype wire
